// [ser_pkg.sv]
// ***************************************
// Status event reporting constants
// ***************************************
package ser_pkg;
	localparam int EXT_W = 16;
	localparam int STD_W = 8;
	localparam int IDX_W = 4;
	localparam int ARG_W = 16;
	localparam int ERR_CODE_W = 16;
	localparam int ERR_TEXT_W = 8;
	localparam int ERRQ_DEPTH = 8;
	localparam int ERRQ_AW = 3;
	localparam int ERRQ_CW = 4;
	localparam int ERRQ_DW = ERR_CODE_W + ERR_TEXT_W;

	// Transition filter encodings
	localparam logic [1:0] FILT_NEVER = 2'h0;
	localparam logic [1:0] FILT_RISE = 2'h1;
	localparam logic [1:0] FILT_FALL = 2'h2;
	localparam logic [1:0] FILT_BOTH = 2'h3;

	// Standard event bit positions
	localparam int STD_OPC = 0;
	localparam int STD_QYE = 2;
	localparam int STD_DDE = 3;
	localparam int STD_EXE = 4;
	localparam int STD_CME = 5;
	localparam int STD_PON = 7;

	// Status byte bit positions
	localparam int SB_EAV = 2;
	localparam int SB_EES = 3;
	localparam int SB_MAV = 4;
	localparam int SB_ESB = 5;
	localparam int SB_MSS = 6;

	// Reset and fixed values
	localparam logic [EXT_W-1:0] EXT_MASK_RST = 16'h0000;
	localparam logic [STD_W-1:0] STD_MASK_RST = 8'h00;
	localparam logic [STD_W-1:0] SRQ_MASK_RST = 8'h00;
	localparam logic [STD_W-1:0] SRQ_WMASK = 8'hBF;
	localparam logic [STD_W-1:0] SB_USED = 8'h3C;
	localparam logic [1:0] FILT_RST = FILT_RISE;
	localparam logic QNONERR_RST = 1'b0;
	localparam logic TEXT_ATTACH_RST = 1'b1;
	localparam logic [ARG_W-1:0] OPT_NONE_ANS = 16'h0000;
	localparam logic [ARG_W-1:0] OPC_ANS = 16'h0001;
	localparam logic [ARG_W-1:0] TST_PASS = 16'h0000;
	localparam logic [ARG_W-1:0] TST_FAIL = 16'h0001;
	localparam logic [ERR_CODE_W-1:0] NO_ERROR_CODE = 16'h0000;

	typedef enum logic [4:0] {
		CMD_EXT_MASK_W, CMD_EXT_MASK_R, CMD_EXT_FLAGS_R, CMD_COND_R,
		CMD_FILT_W, CMD_FILT_R, CMD_ERR_R, CMD_QNONERR_W, CMD_QNONERR_R,
		CMD_TEXT_W, CMD_TEXT_R, CMD_CLEAR, CMD_STD_MASK_W, CMD_STD_MASK_R,
		CMD_STD_FLAGS_R, CMD_OPC, CMD_OPC_Q, CMD_OPT_Q, CMD_RESET,
		CMD_SRQ_MASK_W, CMD_SRQ_MASK_R, CMD_SB_R, CMD_TST_Q, CMD_WAIT, CMD_POLL
	} ser_cmd_t;

	function automatic logic ser_is_query(input ser_cmd_t c);
		unique case (c)
			CMD_EXT_MASK_R, CMD_EXT_FLAGS_R, CMD_COND_R, CMD_FILT_R, CMD_ERR_R,
			CMD_QNONERR_R, CMD_TEXT_R, CMD_STD_MASK_R, CMD_STD_FLAGS_R, CMD_OPC_Q,
			CMD_OPT_Q, CMD_SRQ_MASK_R, CMD_SB_R, CMD_TST_Q, CMD_POLL: ser_is_query = 1'b1;
			default: ser_is_query = 1'b0;
		endcase
	endfunction : ser_is_query
endpackage : ser_pkg

// [ser_errq_if.sv]
`timescale 1ns/1ps
// ***************************************
// Error queue memory port
// ***************************************
interface ser_errq_if;
	import ser_pkg::*;
	logic we;
	logic [ERRQ_AW-1:0] waddr;
	logic [ERRQ_DW-1:0] wdata;
	logic [ERRQ_AW-1:0] raddr;
	logic [ERRQ_DW-1:0] rdata;
	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ser_errq_if

// [ser_errq_mem.sv]
`timescale 1ns/1ps
// ***************************************
// Error queue storage, registered read
// ***************************************
module ser_errq_mem
	import ser_pkg::*;
(
	input wire logic core_clk_i,
	ser_errq_if.mem port
);
	logic [ERRQ_DW-1:0] store [ERRQ_DEPTH];

	// No reset on the array; occupancy lives in the controller
	always_ff @(posedge core_clk_i) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	// Read before write on a shared address
	always_ff @(posedge core_clk_i) begin
		port.rdata <= store[port.raddr];
	end
endmodule : ser_errq_mem

// [ser_core.sv]
`timescale 1ns/1ps
module ser_core
	import ser_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic cmd_valid_i,
	input wire ser_cmd_t cmd_code_i,
	input wire logic [ARG_W-1:0] cmd_arg_i,
	input wire logic [IDX_W-1:0] cmd_index_i,
	input wire logic msg_first_i,
	input wire logic msg_end_i,
	input wire logic [EXT_W-1:0] cond_i,
	input wire logic cmd_error_i,
	input wire logic exec_error_i,
	input wire logic dev_error_i,
	input wire logic query_error_i,
	input wire logic msg_avail_i,
	input wire logic err_push_i,
	input wire logic err_is_error_i,
	input wire logic [ERR_CODE_W-1:0] err_code_i,
	input wire logic [ERR_TEXT_W-1:0] err_text_i,
	input wire logic selftest_fail_i,
	output logic resp_valid_o,
	output logic [ARG_W-1:0] resp_data_o,
	output logic [ERR_TEXT_W-1:0] resp_text_o,
	output logic resp_text_valid_o,
	output logic out_queue_clear_o,
	output logic srq_o,
	output logic [STD_W-1:0] status_byte_o
);
	// ***************************************
	// Command decode
	// ***************************************
	logic take;
	logic is_query;
	logic do_clear;
	logic do_reset;
	assign take = cmd_valid_i;
	assign is_query = take && ser_is_query(cmd_code_i);
	assign do_clear = take && (cmd_code_i == CMD_CLEAR);
	assign do_reset = take && (cmd_code_i == CMD_RESET);

	logic bad_code;
	always_comb begin
		bad_code = 1'b1;
		if (cmd_code_i inside {[CMD_EXT_MASK_W:CMD_POLL]}) begin
			bad_code = 1'b0;
		end
	end

	// ***************************************
	// Settings
	// ***************************************
	logic [EXT_W-1:0] ext_event_mask_cmd;
	logic [STD_W-1:0] std_mask;
	logic [STD_W-1:0] srq_mask;
	logic queue_nonerror_store;
	logic error_text_attach;
	logic [1:0] filt [EXT_W];

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_event_mask_cmd <= EXT_MASK_RST;
		end else if (do_reset) begin
			ext_event_mask_cmd <= EXT_MASK_RST;
		end else if (take && cmd_code_i == CMD_EXT_MASK_W) begin
			ext_event_mask_cmd <= cmd_arg_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			std_mask <= STD_MASK_RST;
		end else if (do_reset) begin
			std_mask <= STD_MASK_RST;
		end else if (take && cmd_code_i == CMD_STD_MASK_W) begin
			std_mask <= cmd_arg_i[STD_W-1:0];
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			srq_mask <= SRQ_MASK_RST;
		end else if (do_reset) begin
			srq_mask <= SRQ_MASK_RST;
		end else if (take && cmd_code_i == CMD_SRQ_MASK_W) begin
			srq_mask <= cmd_arg_i[STD_W-1:0] & SRQ_WMASK;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			queue_nonerror_store <= QNONERR_RST;
			error_text_attach <= TEXT_ATTACH_RST;
		end else if (do_reset) begin
			queue_nonerror_store <= QNONERR_RST;
			error_text_attach <= TEXT_ATTACH_RST;
		end else if (take && cmd_code_i == CMD_QNONERR_W) begin
			queue_nonerror_store <= cmd_arg_i[0];
		end else if (take && cmd_code_i == CMD_TEXT_W) begin
			error_text_attach <= cmd_arg_i[0];
		end
	end

	// ***************************************
	// Condition register and filters
	// ***************************************
	logic [EXT_W-1:0] cond_q;
	logic [EXT_W-1:0] cond_prev;
	logic [EXT_W-1:0] ext_set;

	// Sampled once so one change is seen exactly once
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cond_q <= '0;
			cond_prev <= '0;
		end else begin
			cond_q <= cond_i;
			cond_prev <= cond_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < EXT_W; g++) begin : g_filt
			always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					filt[g] <= FILT_RST;
				end else if (do_reset) begin
					filt[g] <= FILT_RST;
				end else if (take && cmd_code_i == CMD_FILT_W && cmd_index_i == IDX_W'(g)) begin
					filt[g] <= cmd_arg_i[1:0];
				end
			end

			always_comb begin
				unique case (filt[g])
					FILT_RISE: ext_set[g] = cond_q[g] && !cond_prev[g];
					FILT_FALL: ext_set[g] = !cond_q[g] && cond_prev[g];
					FILT_BOTH: ext_set[g] = cond_q[g] != cond_prev[g];
					FILT_NEVER: ext_set[g] = 1'b0;
				endcase
			end
		end
	endgenerate

	// ***************************************
	// Event registers
	// ***************************************
	logic [EXT_W-1:0] ext_flags;
	logic [STD_W-1:0] std_flags;
	logic [STD_W-1:0] std_set;
	logic pon_q;
	logic opt_seen;

	// New events win over a clear in the same cycle
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_flags <= '0;
		end else if (do_clear || (take && cmd_code_i == CMD_EXT_FLAGS_R)) begin
			ext_flags <= ext_set;
		end else begin
			ext_flags <= ext_flags | ext_set;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pon_q <= 1'b1;
		end else begin
			pon_q <= 1'b0;
		end
	end

	// Query after the options query inside one message
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			opt_seen <= 1'b0;
		end else if (msg_end_i) begin
			opt_seen <= 1'b0;
		end else if (take && cmd_code_i == CMD_OPT_Q) begin
			opt_seen <= 1'b1;
		end
	end

	always_comb begin
		std_set = '0;
		std_set[STD_OPC] = take && cmd_code_i == CMD_OPC;
		std_set[STD_QYE] = query_error_i || (is_query && opt_seen);
		std_set[STD_DDE] = dev_error_i;
		std_set[STD_EXE] = exec_error_i;
		std_set[STD_CME] = cmd_error_i || (take && bad_code);
		std_set[STD_PON] = pon_q;
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			std_flags <= '0;
		end else if (do_clear || (take && cmd_code_i == CMD_STD_FLAGS_R)) begin
			std_flags <= std_set;
		end else begin
			std_flags <= std_flags | std_set;
		end
	end

	// ***************************************
	// Error queue, newest entry on top
	// ***************************************
	ser_errq_if errq ();
	ser_errq_mem u_errq_mem (
		.core_clk_i(core_clk_i),
		.port(errq.mem)
	);

	logic [ERRQ_CW-1:0] errq_cnt;
	logic [ERRQ_CW-1:0] next_errq_cnt;
	logic errq_push;
	logic errq_pop;
	logic errq_empty;
	logic errq_full;
	assign errq_empty = errq_cnt == '0;
	assign errq_full = errq_cnt == ERRQ_CW'(ERRQ_DEPTH);
	assign errq_push = err_push_i && (err_is_error_i || queue_nonerror_store);
	assign errq_pop = take && cmd_code_i == CMD_ERR_R && !errq_empty;

	// A full queue overwrites its newest slot; older errors survive
	always_comb begin
		next_errq_cnt = errq_cnt;
		errq.waddr = ERRQ_AW'(errq_cnt);
		if (do_clear) begin
			next_errq_cnt = {{(ERRQ_CW-1){1'b0}}, errq_push};
			errq.waddr = '0;
		end else if (errq_pop) begin
			errq.waddr = ERRQ_AW'(errq_cnt - 1'b1);
			if (!errq_push) begin
				next_errq_cnt = errq_cnt - 1'b1;
			end
		end else if (errq_push) begin
			if (errq_full) begin
				errq.waddr = ERRQ_AW'(errq_cnt - 1'b1);
			end else begin
				next_errq_cnt = errq_cnt + 1'b1;
			end
		end
	end

	assign errq.we = errq_push;
	assign errq.wdata = {err_code_i, err_text_i};
	assign errq.raddr = ERRQ_AW'(errq_cnt - 1'b1);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			errq_cnt <= '0;
		end else begin
			errq_cnt <= next_errq_cnt;
		end
	end

	// ***************************************
	// Status byte and service request
	// ***************************************
	logic [STD_W-1:0] sb_low;
	logic mss;
	logic mss_prev;
	logic rqs;
	logic poll;
	assign poll = take && cmd_code_i == CMD_POLL;

	always_comb begin
		sb_low = '0;
		sb_low[SB_EAV] = !errq_empty;
		sb_low[SB_EES] = |(ext_flags & ext_event_mask_cmd);
		sb_low[SB_MAV] = msg_avail_i;
		sb_low[SB_ESB] = |(std_flags & std_mask);
	end

	assign mss = |(sb_low & srq_mask);

	// Summary rise beats a poll landing in the same cycle
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mss_prev <= 1'b0;
			rqs <= 1'b0;
		end else begin
			mss_prev <= mss;
			if (mss && !mss_prev) begin
				rqs <= 1'b1;
			end else if (poll || !mss) begin
				rqs <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_byte_o <= '0;
			srq_o <= 1'b0;
		end else begin
			status_byte_o <= sb_low | (STD_W'(mss) << SB_MSS);
			srq_o <= rqs;
		end
	end

	// ***************************************
	// Responses and output queue clear
	// ***************************************
	logic [ARG_W-1:0] ans;
	logic [ARG_W-1:0] resp_data_q;
	logic err_sel;

	always_comb begin
		ans = '0;
		unique case (cmd_code_i)
			CMD_EXT_MASK_R: ans = ext_event_mask_cmd;
			CMD_EXT_FLAGS_R: ans = ext_flags;
			CMD_COND_R: ans = cond_q;
			CMD_FILT_R: ans = ARG_W'(filt[cmd_index_i]);
			CMD_QNONERR_R: ans = ARG_W'(queue_nonerror_store);
			CMD_TEXT_R: ans = ARG_W'(error_text_attach);
			CMD_STD_MASK_R: ans = ARG_W'(std_mask);
			CMD_STD_FLAGS_R: ans = ARG_W'(std_flags);
			CMD_OPC_Q: ans = OPC_ANS;
			CMD_OPT_Q: ans = OPT_NONE_ANS;
			CMD_SRQ_MASK_R: ans = ARG_W'(srq_mask);
			CMD_SB_R: ans = ARG_W'(sb_low | (STD_W'(mss) << SB_MSS));
			CMD_TST_Q: ans = selftest_fail_i ? TST_FAIL : TST_PASS;
			CMD_POLL: ans = ARG_W'(sb_low | (STD_W'(rqs) << SB_MSS));
			CMD_ERR_R: ans = NO_ERROR_CODE;
			default: ans = '0;
		endcase
	end

	// Wait and operation complete need no pending state here
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			resp_valid_o <= 1'b0;
			resp_data_q <= '0;
			err_sel <= 1'b0;
			out_queue_clear_o <= 1'b0;
		end else begin
			resp_valid_o <= is_query;
			resp_data_q <= ans;
			err_sel <= errq_pop;
			out_queue_clear_o <= do_clear && msg_first_i;
		end
	end

	// Error reads take the registered memory word directly
	always_comb begin
		resp_text_o = '0;
		resp_text_valid_o = 1'b0;
		if (err_sel) begin
			resp_text_valid_o = error_text_attach;
			if (error_text_attach) begin
				resp_text_o = errq.rdata[ERR_TEXT_W-1:0];
			end
		end
	end

	// Code comes from the memory's read register, so the answer still leaves a flop
	assign resp_data_o = err_sel ? errq.rdata[ERRQ_DW-1:ERR_TEXT_W] : resp_data_q;
endmodule : ser_core

// [ser_core_monitor.sv]
`timescale 1ns/1ps
// ***************************************
// Status event reporting checker
// ***************************************
module ser_core_monitor
	import ser_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic cmd_valid_i,
	input wire ser_cmd_t cmd_code_i,
	input wire logic msg_first_i,
	input wire logic err_push_i,
	input wire logic err_is_error_i,
	input wire logic selftest_fail_i,
	input wire logic resp_valid_o,
	input wire logic [ARG_W-1:0] resp_data_o,
	input wire logic out_queue_clear_o,
	input wire logic srq_o,
	input wire logic [STD_W-1:0] status_byte_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_opc_answer: assert property (cmd_valid_i && cmd_code_i == CMD_OPC_Q |=> resp_valid_o && resp_data_o == 16'h0001)
		else $error("operation complete query answer wrong");
	a_opt_answer: assert property (cmd_valid_i && cmd_code_i == CMD_OPT_Q |=> resp_valid_o && resp_data_o == 16'h0000)
		else $error("options query answer wrong");
	a_tst_answer: assert property (cmd_valid_i && cmd_code_i == CMD_TST_Q |=> resp_valid_o && resp_data_o == {15'h0000, $past(selftest_fail_i)})
		else $error("self-test answer wrong");
	a_wait_silent: assert property (cmd_valid_i && cmd_code_i == CMD_WAIT |=> !resp_valid_o)
		else $error("wait command answered");
	a_outq_clear: assert property (cmd_valid_i && cmd_code_i == CMD_CLEAR && msg_first_i |=> out_queue_clear_o)
		else $error("output queue not cleared");
	a_outq_cause: assert property (out_queue_clear_o |-> $past(cmd_valid_i) && $past(cmd_code_i) == CMD_CLEAR && $past(msg_first_i))
		else $error("output queue cleared without cause");
	a_srq_rise: assert property ($rose(status_byte_o[6]) |-> ##[0:1] srq_o)
		else $error("request bit not set on summary rise");
	a_srq_drop: assert property (!status_byte_o[6] [*2] |-> !srq_o)
		else $error("request bit held without summary");
	a_err_avail: assert property (err_push_i && err_is_error_i |-> ##[1:2] status_byte_o[2])
		else $error("error available bit missing");
	c_poll: cover property (cmd_valid_i && cmd_code_i == CMD_POLL && srq_o);
	c_clear: cover property (out_queue_clear_o);
	c_summary: cover property ($rose(status_byte_o[6]));
endmodule : ser_core_monitor

bind ser_core ser_core_monitor u_mon (.*);

// [ser_ctrl_model.sv]
`timescale 1ns/1ps
// ***************************************
// Remote controller model
// ***************************************
module ser_ctrl_model
	import ser_pkg::*;
(
	input wire logic core_clk_i,
	output logic cmd_valid_o,
	output ser_cmd_t cmd_code_o,
	output logic [ARG_W-1:0] cmd_arg_o,
	output logic [IDX_W-1:0] cmd_index_o,
	output logic msg_first_o,
	output logic msg_end_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = CMD_WAIT;
		cmd_arg_o = 16'h0000;
		cmd_index_o = 4'h0;
		msg_first_o = 1'b0;
		msg_end_o = 1'b0;
	end
	// Argument inverted when idle so a stale value never looks valid
	task automatic send(input ser_cmd_t c, input logic [ARG_W-1:0] a, input logic [IDX_W-1:0] x, input logic f);
		@(negedge core_clk_i);
		cmd_valid_o = 1'b1;
		cmd_code_o = c;
		cmd_arg_o = a;
		cmd_index_o = x;
		msg_first_o = f;
		@(negedge core_clk_i);
		cmd_valid_o = 1'b0;
		cmd_arg_o = ~a;
		msg_first_o = 1'b0;
		if (c == CMD_OPT_Q) begin
			msg_end_o = 1'b1;
			@(negedge core_clk_i);
			msg_end_o = 1'b0;
		end
	endtask : send
	// Misuse on purpose: a query right behind the options query, same message
	task automatic send_late(input ser_cmd_t c);
		@(negedge core_clk_i);
		cmd_valid_o = 1'b1;
		cmd_code_o = CMD_OPT_Q;
		msg_first_o = 1'b0;
		@(negedge core_clk_i);
		cmd_code_o = c;
		@(negedge core_clk_i);
		cmd_valid_o = 1'b0;
		msg_end_o = 1'b1;
		@(negedge core_clk_i);
		msg_end_o = 1'b0;
	endtask : send_late
endmodule : ser_ctrl_model

// [tb_status_event_reporting.sv]
`timescale 1ns/1ps
module tb_status_event_reporting;
	import ser_pkg::*;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cmd_valid_i, msg_first_i, msg_end_i;
	ser_cmd_t cmd_code_i;
	logic [ARG_W-1:0] cmd_arg_i;
	logic [IDX_W-1:0] cmd_index_i;
	logic [EXT_W-1:0] cond_i = 16'h0000;
	logic cmd_error_i = 1'b0, exec_error_i = 1'b0, dev_error_i = 1'b0, query_error_i = 1'b0;
	logic msg_avail_i = 1'b0, err_push_i = 1'b0, err_is_error_i = 1'b0, selftest_fail_i = 1'b0;
	logic [ERR_CODE_W-1:0] err_code_i = 16'h0071;
	logic [ERR_TEXT_W-1:0] err_text_i = 8'h00, txt;
	logic resp_valid_o, resp_text_valid_o, out_queue_clear_o, srq_o;
	logic [ARG_W-1:0] resp_data_o, v, hot;
	logic [ERR_TEXT_W-1:0] resp_text_o;
	logic [STD_W-1:0] status_byte_o;
	logic [IDX_W-1:0] fidx = 4'h0;
	logic [24:0] exp_q[$];
	int mismatches = 0;
	int checks = 0;
	int i;

	initial forever #5 core_clk_i = ~core_clk_i;

	ser_core dut (.*);
	ser_ctrl_model u_ctl (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
		.cmd_arg_o(cmd_arg_i), .cmd_index_o(cmd_index_i), .msg_first_o(msg_first_i), .msg_end_o(msg_end_i));

	// ***************************************
	// Helpers
	// ***************************************
	task automatic chk(input string n, input logic [24:0] e, input logic [24:0] s);
		checks++;
		if (e !== s) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : idle
	task automatic wr(input ser_cmd_t c, input logic [15:0] a);
		u_ctl.send(c, a, fidx, 1'b0);
	endtask : wr
	task automatic ask(input ser_cmd_t c, input logic [24:0] e);
		exp_q.push_back(e);
		u_ctl.send(c, 16'h0000, fidx, 1'b0);
	endtask : ask
	task automatic pulse(ref logic s);
		@(negedge core_clk_i);
		s = 1'b1;
		@(negedge core_clk_i);
		s = 1'b0;
	endtask : pulse
	task automatic sb(input logic [7:0] m, input logic [7:0] e);
		idle(3);
		chk("status byte", {17'h00000, e}, {17'h00000, status_byte_o & m});
	endtask : sb
	task automatic done(input string t);
		for (int k = 0; k < 50 && exp_q.size() != 0; k++) idle(1);
		if (exp_q.size() != 0) begin
			mismatches++;
			stop_test();
		end
		else $display("test %s done", t);
	endtask : done

	// Answer watcher
	always @(negedge core_clk_i) begin
		if (resp_valid_o === 1'b1) begin
			if (exp_q.size() == 0) chk("unexpected answer", 25'h0000000, 25'h1FFFFFF);
			else chk("answer", exp_q.pop_front(), {resp_text_valid_o, resp_text_o, resp_data_o});
		end
	end

	// ***************************************
	// Main sequence
	// ***************************************
	initial begin
		void'($urandom(32'h9EF740D0));
		repeat (16) @(posedge core_clk_i);
		@(negedge core_clk_i);
		sys_rst_i = 1'b0;
		ask(CMD_STD_MASK_R, 25'h0000000);
		ask(CMD_SRQ_MASK_R, 25'h0000000);
		ask(CMD_STD_FLAGS_R, 25'h0000080);
		ask(CMD_STD_FLAGS_R, 25'h0000000);
		done("reset");
		v = 16'($urandom());
		wr(CMD_EXT_MASK_W, v);
		ask(CMD_EXT_MASK_R, {9'h000, v});
		wr(CMD_EXT_MASK_W, 16'hFFFF);
		ask(CMD_EXT_MASK_R, 25'h000FFFF);
		wr(CMD_STD_MASK_W, v & 16'h00FF);
		ask(CMD_STD_MASK_R, {9'h000, v & 16'h00FF});
		ask(CMD_STD_MASK_R, {9'h000, v & 16'h00FF});
		wr(CMD_SRQ_MASK_W, 16'h00FF);
		ask(CMD_SRQ_MASK_R, 25'h00000BF);
		wr(CMD_SRQ_MASK_W, v & 16'h00FF);
		ask(CMD_SRQ_MASK_R, {9'h000, v & 16'h00BF});
		done("masks");
		for (i = 0; i < 4; i++) begin
			fidx = 4'($urandom_range(15));
			hot = 16'h0001 << fidx;
			wr(CMD_FILT_W, 16'(i));
			ask(CMD_FILT_R, 25'(i));
			cond_i[fidx] = 1'b1;
			sb(8'h08, i[0] ? 8'h08 : 8'h00);
			ask(CMD_COND_R, {9'h000, cond_i});
			ask(CMD_EXT_FLAGS_R, i[0] ? {9'h000, hot} : 25'h0000000);
			cond_i[fidx] = 1'b0;
			idle(3);
			ask(CMD_EXT_FLAGS_R, i[1] ? {9'h000, hot} : 25'h0000000);
			ask(CMD_EXT_FLAGS_R, 25'h0000000);
			done("filter");
		end
		wr(CMD_STD_MASK_W, 16'h0020);
		wr(CMD_SRQ_MASK_W, 16'h0020);
		pulse(cmd_error_i);
		sb(8'h60, 8'h60);
		chk("request bit", 25'h0000001, {24'h000000, srq_o});
		ask(CMD_SB_R, 25'h0000060);
		ask(CMD_SB_R, 25'h0000060);
		ask(CMD_POLL, 25'h0000060);
		idle(2);
		chk("request bit", 25'h0000000, {24'h000000, srq_o});
		ask(CMD_STD_FLAGS_R, 25'h0000020);
		sb(8'h20, 8'h00);
		wr(CMD_STD_MASK_W, 16'h00FB);
		pulse(query_error_i);
		sb(8'h20, 8'h00);
		ask(CMD_STD_FLAGS_R, 25'h0000004);
		wr(CMD_OPC, 16'h0000);
		wr(CMD_WAIT, 16'h0000);
		ask(CMD_STD_FLAGS_R, 25'h0000001);
		ask(CMD_OPC_Q, 25'h0000001);
		ask(CMD_OPT_Q, 25'h0000000);
		exp_q.push_back(25'h0000000);
		exp_q.push_back(25'h0000001);
		u_ctl.send_late(CMD_OPC_Q);
		ask(CMD_STD_FLAGS_R, 25'h0000004);
		ask(CMD_TST_Q, 25'h0000000);
		selftest_fail_i = 1'b1;
		ask(CMD_TST_Q, 25'h0000001);
		wr(ser_cmd_t'(5'h1F), 16'h0000);
		ask(CMD_STD_FLAGS_R, 25'h0000020);
		done("events");
		txt = 8'($urandom());
		err_text_i = txt;
		pulse(err_push_i);
		sb(8'h04, 8'h00);
		err_is_error_i = 1'b1;
		pulse(err_push_i);
		err_text_i = ~txt;
		pulse(err_push_i);
		sb(8'h04, 8'h04);
		ask(CMD_ERR_R, {1'b1, ~txt, err_code_i});
		ask(CMD_ERR_R, {1'b1, txt, err_code_i});
		sb(8'h04, 8'h00);
		ask(CMD_ERR_R, 25'h0000000);
		wr(CMD_TEXT_W, 16'h0000);
		wr(CMD_QNONERR_W, 16'h0001);
		ask(CMD_QNONERR_R, 25'h0000001);
		err_is_error_i = 1'b0;
		pulse(err_push_i);
		ask(CMD_ERR_R, {1'b0, 8'h00, err_code_i});
		done("errors");
		err_is_error_i = 1'b1;
		pulse(err_push_i);
		pulse(cmd_error_i);
		cond_i[fidx] = 1'b1;
		sb(8'h0C, 8'h0C);
		u_ctl.send(CMD_CLEAR, 16'h0000, fidx, 1'b1);
		sb(8'h0C, 8'h00);
		ask(CMD_STD_FLAGS_R, 25'h0000000);
		ask(CMD_EXT_FLAGS_R, 25'h0000000);
		wr(CMD_CLEAR, 16'h0000);
		msg_avail_i = 1'b1;
		sb(8'h10, 8'h10);
		msg_avail_i = 1'b0;
		done("clear");
		wr(CMD_RESET, 16'h0000);
		ask(CMD_STD_MASK_R, 25'h0000000);
		ask(CMD_SRQ_MASK_R, 25'h0000000);
		ask(CMD_EXT_MASK_R, 25'h0000000);
		ask(CMD_FILT_R, 25'h0000001);
		ask(CMD_TEXT_R, 25'h0000001);
		ask(CMD_QNONERR_R, 25'h0000000);
		done("reset command");
		stop_test();
	end
endmodule : tb_status_event_reporting
